// ===== design/dtc_regs.vh
// register offsets, field positions, reset values and latency figures for the termination block
`ifndef DTC_REGS_VH
`define DTC_REGS_VH

// register byte offsets
`define DTC_OFF_MODE_ONE   8'h00
`define DTC_OFF_MODE_TWO   8'h04
`define DTC_OFF_MODE_FIVE  8'h08
`define DTC_OFF_LATENCY    8'h0C
`define DTC_OFF_CONTROL    8'h10
`define DTC_OFF_STATUS     8'h14

// nominal value field of mode_register_one (bits 10:8)
`define DTC_NOM_LSB  8
`define DTC_NOM_MSB  10
// write value field of mode_register_two (bits 11:9)
`define DTC_WR_LSB   9
`define DTC_WR_MSB   11
// park value field of mode_register_five (bits 8:6)
`define DTC_PARK_LSB 6
`define DTC_PARK_MSB 8

// latency register fields, one byte each
`define DTC_CWL_LSB  0
`define DTC_CL_LSB   8
`define DTC_AL_LSB   16
`define DTC_PL_LSB   24

// control register bits
`define DTC_CTL_PRE2 0
`define DTC_CTL_CRC  1

// reset values
`define DTC_RST_MODE   32'h0000_0000
`define DTC_RST_LAT    32'h0000_0E0B
// latency register fields after reset, matching the packed word above
`define DTC_RST_LAT_CWL 8'h0B
`define DTC_RST_LAT_CL  8'h0E
`define DTC_RST_CTL    2'h0

// termination state encodings
`define DTC_ST_HIZ   2'h0
`define DTC_ST_PARK  2'h1
`define DTC_ST_NOM   2'h2
`define DTC_ST_WR    2'h3

// latency offsets in command clock cycles
`define DTC_X_PRE1       9'h002
`define DTC_X_PRE2       9'h003
`define DTC_RD4_PRE1     9'h004
`define DTC_RD4_PRE2     9'h005
`define DTC_RD8_PRE1     9'h006
`define DTC_RD8_PRE2     9'h007
`define DTC_WN4_PRE1     9'h004
`define DTC_WN4_PRE1_CRC 9'h007
`define DTC_WN4_PRE2     9'h005
`define DTC_WN4_PRE2_CRC 9'h008
`define DTC_WN8_PRE1     9'h006
`define DTC_WN8_PRE1_CRC 9'h007
`define DTC_WN8_PRE2     9'h007
`define DTC_WN8_PRE2_CRC 9'h008

// history depth in command clock cycles
`define DTC_HIST_DEPTH   128

`endif

// ===== design/dtc_hist.v
// event history shift register with an age window detector
`timescale 1ns/1ps
module dtc_hist (
	input wire clk,
	input wire srst,
	input wire step,
	input wire din,
	input wire [8:0] lo,
	input wire [8:0] hi,
	output wire hit
);
	localparam DEPTH = 128;

	reg [DEPTH-1:0] age_q;
	wire [DEPTH-1:0] in_win;

	// bit i holds the event seen i command edges ago
	always @(posedge clk) begin
		if (srst) begin
			age_q <= {DEPTH{1'b0}};
		end else if (step) begin
			age_q <= {age_q[DEPTH-2:0], din};
		end
	end

	// an event is live while its age lies in [lo, hi)
	genvar i;
	generate
		for (i = 0; i < DEPTH; i = i + 1) begin : g_win
			localparam [8:0] AGE = i;
			assign in_win[i] = age_q[i] & (AGE >= lo) & (AGE < hi);
		end
	endgenerate

	assign hit = |in_win;
endmodule // dtc_hist

// ===== design/dtc_top.v
// on-die termination control for one data byte lane
// Functional notes
// - synchronous timing whenever delay loop is locked
// - synchronous timing in active, idle, power-down states
// - nominal follows pin after direct latencies
// - direct latencies are write latency minus two/three
// - additive and parity latency in every latency
// - read turns termination off after read latency minus two/three
// - chop-4 read restores park four/five later
// - burst-8 read restores park six/seven later
// - never terminate while driving read data; reads turn it off only with delay loop locked
// - dynamic switching only when write field bit 0 or 1 set
// - nominal, write, park values from mode fields
// - no write: nominal per pin, park when low
// - any write selects write value after latency
// - write value released after chop-4/burst-8 latency
// - release latencies track crc and long preamble
// - no dynamic switching with delay loop off
// - priority: read off, write, nominal, park
// - self-refresh forces high impedance termination
// - nominal field zero makes pin ignored
// - change latency and release adders per mode
`timescale 1ns/1ps
`include "dtc_regs.vh"
module dtc_top (
	input wire clk,
	input wire srst,
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata_q,
	input wire cmd_clk,
	input wire termination_control_pin,
	input wire cmd_write,
	input wire cmd_read,
	input wire cmd_chop4,
	input wire dll_locked,
	input wire self_refresh,
	output reg [1:0] term_state_q,
	output reg [2:0] term_value_q,
	output reg term_on_q
);

	// software visible configuration
	reg [2:0] nom_val_q;
	reg [2:0] wr_val_q;
	reg [2:0] park_val_q;
	reg [7:0] cwl_q;
	reg [7:0] cl_q;
	reg [7:0] al_q;
	reg [7:0] pl_q;
	reg pre2_q;
	reg crc_q;

	// pin synchronisers: stage one feeds stage two only
	reg [4:0] pin_s1_q;
	reg [4:0] pin_s2_q;
	reg ck_prev_q;
	wire ck_rise;
	wire odt_s;
	wire wr_s;
	wire rd_s;
	wire bc4_s;

	// computed latencies, in command clock cycles
	wire [8:0] wl;
	wire [8:0] rl;
	wire [8:0] x_sub;
	wire [8:0] direct_lat;
	wire [8:0] rd_off_lat;
	wire [8:0] rd_on4_lat;
	wire [8:0] rd_on8_lat;
	wire [8:0] cnw_lat;
	wire [8:0] cwn4_lat;
	wire [8:0] cwn8_lat;
	wire [8:0] add4;
	wire [8:0] add8;

	// window hits from the history lines
	wire pin_hit;
	wire rd4_hit;
	wire rd8_hit;
	wire wr4_hit;
	wire wr8_hit;
	wire rd_off;
	wire wr_on;
	wire nom_on;
	wire dyn_en;
	wire sync_mode;
	wire pin_used;

	reg [1:0] state_d;
	reg [2:0] value_d;
	reg [31:0] rdata_d;

	// saturating subtract so short latency settings never wrap
	function [8:0] sat_sub;
		input [8:0] a;
		input [8:0] b;
		begin
			if (a > b) begin
				sat_sub = a - b;
			end else begin
				sat_sub = 9'h000;
			end
		end
	endfunction

	// register writes; fields sit at their mode register bit positions
	always @(posedge clk) begin
		if (srst) begin
			nom_val_q <= 3'h0;
			wr_val_q <= 3'h0;
			park_val_q <= 3'h0;
			cwl_q <= `DTC_RST_LAT_CWL;
			cl_q <= `DTC_RST_LAT_CL;
			al_q <= 8'h00;
			pl_q <= 8'h00;
			pre2_q <= 1'b0;
			crc_q <= 1'b0;
		end else if (reg_wr) begin
			case (reg_addr)
				`DTC_OFF_MODE_ONE: begin
					nom_val_q <= reg_wdata[`DTC_NOM_MSB:`DTC_NOM_LSB];
				end
				`DTC_OFF_MODE_TWO: begin
					wr_val_q <= reg_wdata[`DTC_WR_MSB:`DTC_WR_LSB];
				end
				`DTC_OFF_MODE_FIVE: begin
					park_val_q <= reg_wdata[`DTC_PARK_MSB:`DTC_PARK_LSB];
				end
				`DTC_OFF_LATENCY: begin
					cwl_q <= reg_wdata[`DTC_CWL_LSB+7:`DTC_CWL_LSB];
					cl_q <= reg_wdata[`DTC_CL_LSB+7:`DTC_CL_LSB];
					al_q <= reg_wdata[`DTC_AL_LSB+7:`DTC_AL_LSB];
					pl_q <= reg_wdata[`DTC_PL_LSB+7:`DTC_PL_LSB];
				end
				`DTC_OFF_CONTROL: begin
					pre2_q <= reg_wdata[`DTC_CTL_PRE2];
					crc_q <= reg_wdata[`DTC_CTL_CRC];
				end
				default: begin
					nom_val_q <= nom_val_q;
				end
			endcase
		end
	end

	// read mux; unmapped offsets read zero
	always @* begin
		rdata_d = 32'h0000_0000;
		case (reg_addr)
			`DTC_OFF_MODE_ONE: begin
				rdata_d[`DTC_NOM_MSB:`DTC_NOM_LSB] = nom_val_q;
			end
			`DTC_OFF_MODE_TWO: begin
				rdata_d[`DTC_WR_MSB:`DTC_WR_LSB] = wr_val_q;
			end
			`DTC_OFF_MODE_FIVE: begin
				rdata_d[`DTC_PARK_MSB:`DTC_PARK_LSB] = park_val_q;
			end
			`DTC_OFF_LATENCY: begin
				rdata_d = {pl_q, al_q, cl_q, cwl_q};
			end
			`DTC_OFF_CONTROL: begin
				rdata_d[`DTC_CTL_PRE2] = pre2_q;
				rdata_d[`DTC_CTL_CRC] = crc_q;
			end
			`DTC_OFF_STATUS: begin
				rdata_d[1:0] = term_state_q;
				rdata_d[4:2] = term_value_q;
				rdata_d[5] = term_on_q;
				rdata_d[6] = rd_off;
				rdata_d[7] = wr_on;
				rdata_d[8] = sync_mode;
				rdata_d[9] = dyn_en;
			end
			default: begin
				rdata_d = 32'h0000_0000;
			end
		endcase
	end

	// read data stand only in the cycle after the strobe
	always @(posedge clk) begin
		if (srst) begin
			reg_rdata_q <= 32'h0000_0000;
		end else if (reg_rd) begin
			reg_rdata_q <= rdata_d;
		end else begin
			reg_rdata_q <= 32'h0000_0000;
		end
	end

	// two-flop synchronisers for the command clock and every controller pin
	always @(posedge clk) begin
		if (srst) begin
			pin_s1_q <= 5'h00;
			pin_s2_q <= 5'h00;
			ck_prev_q <= 1'b0;
		end else begin
			pin_s1_q <= {cmd_clk, termination_control_pin, cmd_write, cmd_read, cmd_chop4};
			pin_s2_q <= pin_s1_q;
			ck_prev_q <= pin_s2_q[4];
		end
	end

	// pins share one delay with the clock, so each rise samples stable levels;
	// this assumes the controller moves its pins well away from the rising edge
	assign ck_rise = pin_s2_q[4] & ~ck_prev_q;
	assign odt_s = pin_s2_q[3];
	assign wr_s = pin_s2_q[2];
	assign rd_s = pin_s2_q[1];
	assign bc4_s = pin_s2_q[0];

	// write and read latencies include additive and parity latency
	assign wl = {1'b0, cwl_q} + {1'b0, al_q} + {1'b0, pl_q};
	assign rl = {1'b0, cl_q} + {1'b0, al_q} + {1'b0, pl_q};
	assign x_sub = pre2_q ? `DTC_X_PRE2 : `DTC_X_PRE1;

	// direct latencies; on and off share one figure, so one tap serves both
	assign direct_lat = sat_sub(wl, x_sub);
	assign rd_off_lat = sat_sub(rl, x_sub);
	assign rd_on4_lat = rd_off_lat + (pre2_q ? `DTC_RD4_PRE2 : `DTC_RD4_PRE1);
	assign rd_on8_lat = rd_off_lat + (pre2_q ? `DTC_RD8_PRE2 : `DTC_RD8_PRE1);

	// dynamic write latencies and their release adders
	assign cnw_lat = sat_sub(wl, x_sub);
	assign add4 = crc_q ? (pre2_q ? `DTC_WN4_PRE2_CRC : `DTC_WN4_PRE1_CRC) :
		(pre2_q ? `DTC_WN4_PRE2 : `DTC_WN4_PRE1);
	assign add8 = crc_q ? (pre2_q ? `DTC_WN8_PRE2_CRC : `DTC_WN8_PRE1_CRC) :
		(pre2_q ? `DTC_WN8_PRE2 : `DTC_WN8_PRE1);
	assign cwn4_lat = cnw_lat + add4;
	assign cwn8_lat = cnw_lat + add8;

	// pin history: the nominal value is live one cycle at the tap age
	dtc_hist u_pin (
		.clk(clk),
		.srst(srst),
		.step(ck_rise),
		.din(odt_s),
		.lo(direct_lat),
		.hi(direct_lat + 9'h001),
		.hit(pin_hit)
	);

	// chop-4 reads disable termination until their shorter turn-on point
	dtc_hist u_rd4 (
		.clk(clk),
		.srst(srst),
		.step(ck_rise),
		.din(rd_s & bc4_s),
		.lo(rd_off_lat),
		.hi(rd_on4_lat),
		.hit(rd4_hit)
	);

	// burst-8 reads hold termination off two cycles longer
	dtc_hist u_rd8 (
		.clk(clk),
		.srst(srst),
		.step(ck_rise),
		.din(rd_s & ~bc4_s),
		.lo(rd_off_lat),
		.hi(rd_on8_lat),
		.hit(rd8_hit)
	);

	// chop-4 writes: plain, auto-precharge and fixed-chop variants alike
	dtc_hist u_wr4 (
		.clk(clk),
		.srst(srst),
		.step(ck_rise),
		.din(wr_s & bc4_s),
		.lo(cnw_lat),
		.hi(cwn4_lat),
		.hit(wr4_hit)
	);

	// burst-8 writes, whether fixed by mode or chosen on the fly
	dtc_hist u_wr8 (
		.clk(clk),
		.srst(srst),
		.step(ck_rise),
		.din(wr_s & ~bc4_s),
		.lo(cnw_lat),
		.hi(cwn8_lat),
		.hit(wr8_hit)
	);

	// synchronous timing whenever the delay loop is locked; power-down and
	// active states keep the same latencies, only an unlocked delay loop leaves them
	assign sync_mode = dll_locked;

	// dynamic switching needs write field bit 0 or 1 set and a locked delay loop;
	// clearing the field to zero is how the controller turns it off
	assign dyn_en = (wr_val_q[0] | wr_val_q[1]) & sync_mode;

	// a zero nominal field makes the pin irrelevant
	assign pin_used = (nom_val_q != 3'h0);

	// with the loop off, nominal simply follows the sampled pin without latency
	assign nom_on = pin_used & (sync_mode ? pin_hit : odt_s);
	assign rd_off = sync_mode & (rd4_hit | rd8_hit);
	assign wr_on = dyn_en & (wr4_hit | wr8_hit);

	// priority: self-refresh, read-off, write, nominal, park
	always @* begin
		state_d = `DTC_ST_HIZ;
		value_d = 3'h0;
		if (self_refresh) begin
			state_d = `DTC_ST_HIZ;
			value_d = 3'h0;
		end else if (rd_off) begin
			state_d = `DTC_ST_HIZ;
			value_d = 3'h0;
		end else if (wr_on) begin
			state_d = `DTC_ST_WR;
			value_d = wr_val_q;
		end else if (nom_on) begin
			state_d = `DTC_ST_NOM;
			value_d = nom_val_q;
		end else if (park_val_q != 3'h0) begin
			state_d = `DTC_ST_PARK;
			value_d = park_val_q;
		end else begin
			state_d = `DTC_ST_HIZ;
			value_d = 3'h0;
		end
	end

	// registered termination outputs; off value always reads as high impedance
	always @(posedge clk) begin
		if (srst) begin
			term_state_q <= `DTC_ST_HIZ;
			term_value_q <= 3'h0;
			term_on_q <= 1'b0;
		end else begin
			term_state_q <= state_d;
			term_value_q <= value_d;
			term_on_q <= (value_d != 3'h0);
		end
	end

endmodule // dtc_top

// ===== tb/dtc_top_checker.sv
// concurrent checks on the termination block ports
`timescale 1ns/1ps
`include "dtc_regs.vh"
module dtc_top_checker (
	input wire clk,
	input wire srst,
	input wire [7:0] reg_addr,
	input wire reg_rd,
	input wire [31:0] reg_rdata_q,
	input wire dll_locked,
	input wire self_refresh,
	input wire [1:0] term_state_q,
	input wire [2:0] term_value_q,
	input wire term_on_q
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	// outputs leave reset cleared, read data included
	chk_reset_clear: assert property ($past(srst) |->
		term_state_q == `DTC_ST_HIZ && !term_on_q && reg_rdata_q == 32'h0000_0000)
		else $error("outputs not clear after reset");
	// the enable flag must never drift from the value it reports
	chk_on_matches_value: assert property (term_on_q == (term_value_q != 3'h0))
		else $error("enable flag disagrees with value");
	chk_hiz_no_value: assert property (term_state_q == `DTC_ST_HIZ |->
		term_value_q == 3'h0) else $error("value present in high impedance");
	// two cycles of self refresh are enough for the registered outputs to follow
	chk_selfref_hiz: assert property (self_refresh && $past(self_refresh) |->
		term_state_q == `DTC_ST_HIZ && !term_on_q) else $error("termination on in self refresh");
	// read data stands only in the cycle after the strobe
	chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata_q == 32'h0000_0000)
		else $error("read data outside its cycle");
	chk_unmapped_zero: assert property ($past(reg_rd) && $past(reg_addr) == 8'h20 |->
		reg_rdata_q == 32'h0000_0000) else $error("unmapped read not zero");
	chk_dll_off_write: assert property (!$past(dll_locked) && !$past(dll_locked, 2) |->
		term_state_q != `DTC_ST_WR) else $error("write value used with loop unlocked");
	chk_write_dynamic: assert property (term_state_q == `DTC_ST_WR |->
		term_value_q[1:0] != 2'h0) else $error("write value without dynamic enable");
	chk_nominal_set: assert property (term_state_q == `DTC_ST_NOM |->
		term_value_q != 3'h0) else $error("nominal state with empty field");
endmodule // dtc_top_checker

// ===== tb/dtc_ctrl_model.sv
// memory controller model: command clock, termination pin and commands
`timescale 1ns/1ps
module dtc_ctrl_model (
	output logic cmd_clk,
	output logic termination_control_pin,
	output logic cmd_write,
	output logic cmd_read,
	output logic cmd_chop4
);
	int rise_n = 0;
	// the command clock runs free, as a memory clock does between commands
	initial begin
		cmd_clk = 1'b0;
		cmd_chop4 = 1'b0;
		drv(1'b0, 1'b0, 1'b0, 1'b0);
		forever #200 cmd_clk = ~cmd_clk;
	end
	// rises are counted so the bench can place checks at an exact age
	always @(posedge cmd_clk) begin
		rise_n <= rise_n + 1;
	end
	// called after a falling edge so levels are steady around the next rise;
	// the burst-type line shows the inverse of its last value when idle
	task automatic drv(input logic p, input logic w, input logic r, input logic c);
		termination_control_pin = p;
		cmd_write = w;
		cmd_read = r;
		cmd_chop4 = (w | r) ? c : ~cmd_chop4;
	endtask
endmodule // dtc_ctrl_model

// ===== tb/dtc_top_tb_top.sv
// self-checking bench for the termination control block
`timescale 1ns/1ps
`include "dtc_regs.vh"
module dtc_top_tb_top;
	localparam logic [1:0] st_hz = `DTC_ST_HIZ, st_pk = `DTC_ST_PARK;
	localparam logic [1:0] st_nm = `DTC_ST_NOM, st_wr = `DTC_ST_WR;
	logic clk, srst, reg_wr, reg_rd, dll_locked, self_refresh, rdc;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata;
	logic [2:0] m3;
	logic [3:0] add_tbl [8] = '{6, 7, 7, 8, 4, 7, 5, 8};
	logic [31:0] wr2_tbl [3] = '{32'h0000_0400, 32'h0000_0800, 32'h0000_0000};
	wire [31:0] reg_rdata_q;
	wire cmd_clk, termination_control_pin, cmd_write, cmd_read, cmd_chop4, term_on_q;
	wire [1:0] term_state_q;
	wire [2:0] term_value_q;
	int fails = 0;
	int checked = 0;
	int cyc = 0;
	int base = 0;
	int lat, on_a, rel_a;
	dtc_top dut_u (.clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q,
		.cmd_clk, .termination_control_pin, .cmd_write, .cmd_read, .cmd_chop4, .dll_locked,
		.self_refresh, .term_state_q, .term_value_q, .term_on_q);
	dtc_ctrl_model ctl_u (.cmd_clk, .termination_control_pin, .cmd_write, .cmd_read,
		.cmd_chop4);
	// system clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// a hang ends the run instead of stalling it
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			results();
		end
	end
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		cmp(reg_rdata_q & mask, exp, "register read");
	endtask
	// idle long enough for old link events to age out, then start at age zero
	task automatic go(input logic p, input logic w, input logic r, input logic c);
		repeat (12) @(posedge cmd_clk);
		@(negedge cmd_clk);
		ctl_u.drv(p, w, r, c);
		base = ctl_u.rise_n + 1;
	endtask
	// new pin level in the low phase after age a, so it is registered at a + 1
	task automatic at_neg(input int a, input logic p);
		wait (ctl_u.rise_n == base + a);
		@(negedge cmd_clk);
		ctl_u.drv(p, 1'b0, 1'b0, 1'b0);
	endtask
	// look late in the link cycle: the sync delay has passed, the next rise has not
	task automatic chk(input int a, input logic [1:0] st, input logic [2:0] v);
		wait (ctl_u.rise_n == base + a);
		repeat (6) @(posedge clk);
		cmp({26'h0, term_on_q, term_value_q, term_state_q}, {26'h0, v != 3'h0, v, st},
			$sformatf("termination at age %0d", a));
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		srst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0000_0000;
		dll_locked = 1'b1;
		self_refresh = 1'b0;
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		rd(`DTC_OFF_LATENCY, 32'hFFFF_FFFF, `DTC_RST_LAT);
		rd(8'h20, 32'hFFFF_FFFF, 32'h0000_0000);
		wr(`DTC_OFF_MODE_ONE, 32'h0000_0300);
		wr(`DTC_OFF_MODE_TWO, 32'h0000_0200);
		wr(`DTC_OFF_MODE_FIVE, 32'h0000_0080);
		rd(`DTC_OFF_MODE_ONE, 32'h0000_0700, 32'h0000_0300);
		rd(`DTC_OFF_STATUS, 32'h0000_03FF, 32'h0000_0329);
		$display("test registers done");
		// direct latency with short preamble, long preamble, then added latencies
		for (int p = 0; p < 3; p++) begin
			lat = (p == 2) ? 11 : 9 - p;
			wr(`DTC_OFF_CONTROL, {31'h0, p == 1});
			wr(`DTC_OFF_LATENCY, (p == 2) ? 32'h0101_0E0B : `DTC_RST_LAT);
			go(1'b1, 1'b0, 1'b0, 1'b0);
			at_neg(5, 1'b0);
			chk(lat - 1, st_pk, 3'h2);
			chk(lat, st_nm, 3'h3);
			chk(lat + 5, st_nm, 3'h3);
			chk(lat + 6, st_pk, 3'h2);
		end
		wr(`DTC_OFF_LATENCY, `DTC_RST_LAT);
		wr(`DTC_OFF_CONTROL, 32'h0000_0000);
		$display("test direct done");
		go(1'b1, 1'b1, 1'b0, 1'b0);
		at_neg(0, 1'b1);
		at_neg(5, 1'b0);
		chk(8, st_pk, 3'h2);
		chk(9, st_wr, 3'h1);
		chk(14, st_wr, 3'h1);
		chk(15, st_pk, 3'h2);
		go(1'b1, 1'b0, 1'b1, 1'b0);
		at_neg(0, 1'b1);
		chk(11, st_nm, 3'h3);
		chk(12, st_hz, 3'h0);
		at_neg(16, 1'b0);
		chk(17, st_hz, 3'h0);
		chk(18, st_nm, 3'h3);
		$display("test priority done");
		// every preamble, crc and burst mix for writes, then every preamble and burst mix for reads
		for (int m = 0; m < 12; m++) begin
			rdc = (m >= 8);
			m3 = rdc ? {m[1], m[0], 1'b0} : m[2:0];
			wr(`DTC_OFF_CONTROL, {30'h0, m3[0], m3[1]});
			on_a = (rdc ? 12 : 9) - m3[1];
			rel_a = on_a + add_tbl[m3];
			go(1'b0, !rdc, rdc, m3[2]);
			at_neg(0, 1'b0);
			chk(on_a - 1, st_pk, 3'h2);
			chk(on_a, rdc ? st_hz : st_wr, rdc ? 3'h0 : 3'h1);
			chk(rel_a - 1, rdc ? st_hz : st_wr, rdc ? 3'h0 : 3'h1);
			chk(rel_a, st_pk, 3'h2);
		end
		wr(`DTC_OFF_CONTROL, 32'h0000_0000);
		$display("test latency table done");
		wr(`DTC_OFF_MODE_ONE, 32'h0000_0000);
		go(1'b1, 1'b0, 1'b0, 1'b0);
		at_neg(5, 1'b0);
		chk(9, st_pk, 3'h2);
		wr(`DTC_OFF_MODE_ONE, 32'h0000_0300);
		for (int i = 0; i < 3; i++) begin
			wr(`DTC_OFF_MODE_TWO, wr2_tbl[i]);
			go(1'b0, 1'b1, 1'b0, 1'b0);
			at_neg(0, 1'b0);
			chk(9, (i == 0) ? st_wr : st_pk, 3'h2);
		end
		$display("test refusals done");
		wr(`DTC_OFF_MODE_TWO, 32'h0000_0200);
		dll_locked <= 1'b0;
		rd(`DTC_OFF_STATUS, 32'h0000_0100, 32'h0000_0000);
		go(1'b0, 1'b1, 1'b0, 1'b0);
		at_neg(0, 1'b0);
		chk(9, st_pk, 3'h2);
		dll_locked <= 1'b1;
		self_refresh <= 1'b1;
		repeat (3) @(posedge clk);
		rd(`DTC_OFF_STATUS, 32'h0000_003F, 32'h0000_0000);
		self_refresh <= 1'b0;
		$display("test loop off and self refresh done");
		results();
	end
endmodule // dtc_top_tb_top
bind dtc_top dtc_top_checker chk_u (.clk, .srst, .reg_addr, .reg_rd, .reg_rdata_q, .dll_locked,
	.self_refresh, .term_state_q, .term_value_q, .term_on_q);
